// file: bench/fsl_flash_model.sv
// Purpose: behavioural flash device on the far side of the host controller
// Assumes: word mode, sixteen sectors of 32K words, open-drain ready line
// Notes: times count core clocks; fail_inject fails the operation that ends
`timescale 1ns/1ps
`default_nettype none
module fsl_flash_model #(
  parameter int BUSY_CYC = 150,
  parameter logic [15:0] FACT_WORD = 16'h5A5A  // arbitrary value
) (
  input wire logic core_clk,
  input wire logic [18:0] fl_addr,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_reset_n,
  input wire logic [15:0] dq,
  input wire logic fail_inject,
  output logic [15:0] dev_dq,
  output logic busy_pull
);
  import fsl_pkg::*;
  bit [15:0] mem [0:524287];
  logic [18:0] h_a [0:5];
  logic [15:0] h_d [0:5];
  logic [15:0] prot [0:3];
  logic [15:0] lock = '0;
  logic [15:0] last = '0;
  logic [15:0] rd, pd;
  logic [18:0] loc;
  logic [1:0] cfg = CFG_RESET;
  logic prot_lk = 0, busy = 0, susp = 0, stat = 0, failed = 0, idm = 0, tog = 0;
  int kind = 0;
  int cnt = 0;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  function automatic bit hit(int i, logic [7:0] d, logic [18:0] a);
    return h_a[i] == a && h_d[i][7:0] == d;
  endfunction : hit
  function automatic bit unl(int i);
    return hit(i + 1, DAT_UNLOCK1, ADR_UNLOCK1) && hit(i, DAT_UNLOCK2, ADR_UNLOCK2);
  endfunction : unl
  task automatic start(int k);
    kind = k;
    loc = fl_addr;
    pd = dq;
    cnt = 0;
    if (k < 2 && lock[fl_addr[18:15]]) begin
      stat = 1;
      failed = 1;
    end else begin
      busy = 1;
    end
  endtask : start
  // the device latches each command word on the rising write strobe
  always @(posedge fl_we_n) begin
    if (fl_ce_n === 1'b0 && fl_reset_n === 1'b1) begin
      for (int i = 5; i > 0; i--) begin
        h_a[i] = h_a[i-1];
        h_d[i] = h_d[i-1];
      end
      h_a[0] = fl_addr;
      h_d[0] = dq;
      if (busy) begin
        susp = dq[7:0] == DAT_SUSPEND;
        busy = !susp;
      end else if (susp && dq[7:0] == DAT_RESUME) begin
        susp = 0;
        busy = 1;
      end else if (unl(4) && hit(3, DAT_SETUP, ADR_UNLOCK1) && unl(1)) begin
        if (dq[7:0] == DAT_CHIP_ERASE) start(2);
        if (dq[7:0] == DAT_SECTOR_ERASE && !susp) start(1);
        if (dq[7:0] == DAT_LOCKDOWN) lock[fl_addr[18:15]] = 1;
      end else if (unl(2) && h_a[1] == ADR_UNLOCK1) begin
        if (h_d[1][7:0] == DAT_PROGRAM) start(0);
        if (h_d[1][7:0] == DAT_SET_CFG) cfg = dq[1:0];
        if (h_d[1][7:0] == DAT_PROT_PGM && !prot_lk) prot[fl_addr[1:0]] = dq;
        if (h_d[1][7:0] == DAT_PROT_LOCK && !dq[1]) prot_lk = 1;
      end else if (unl(1) && h_a[0] == ADR_UNLOCK1) begin
        if (dq[7:0] == DAT_ID_ENTRY) idm = 1;
        if (dq[7:0] == DAT_ID_EXIT) {idm, stat} = 2'b00;
      end
    end
  end
  always @(posedge core_clk) begin
    if (busy) begin
      cnt++;
      if (cnt >= BUSY_CYC) begin
        busy = 0;
        failed = fail_inject;
        stat = fail_inject || cfg != CFG_AUTO;
        if (!fail_inject && kind == 0) mem[loc] = mem[loc] & pd;
        for (int i = 0; i < 524288 && !fail_inject && kind > 0; i++) begin
          if (!lock[i[18:15]] && (kind == 2 || i[18:15] == loc[18:15])) mem[i] = 16'hFFFF;
        end
      end
    end
  end
  // configuration survives the reset pin, lockdowns do not
  always @(negedge fl_reset_n) begin
    lock = '0;
    busy = 0;
    susp = 0;
    stat = 0;
    idm = 0;
  end
  always @(negedge fl_oe_n) if (fl_ce_n === 1'b0 && busy) tog = ~tog;
  always @(posedge fl_oe_n) last = rd;
  always_comb begin
    if (busy) rd = {8'h00, cfg == CFG_AUTO && kind == 0 && ~pd[7], tog, 6'h00};
    else if (stat) rd = {8'h00, !failed || (kind == 0 && ~pd[7]), tog, failed, 5'h00};
    else if (idm && fl_addr[14:0] == 15'h0002) rd = {15'h0000, lock[fl_addr[18:15]]};
    else if (idm && fl_addr == ADR_USER_LOCK) rd = {14'h3FFF, ~prot_lk, 1'b1};
    else if (idm) rd = fl_addr[7:2] == 6'h21 ? prot[fl_addr[1:0]] : FACT_WORD;
    else rd = mem[fl_addr];
  end
  // a released bus shows the inverse of the last word, never a held value
  assign dev_dq = (fl_ce_n === 1'b0 && fl_oe_n === 1'b0) ? rd : ~last;
  assign busy_pull = busy;
endmodule : fsl_flash_model
`default_nettype wire

// file: bench/fsl_host_ctrl_tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: behavioural flash model beside it, pull-up on the ready line
// Notes: expected array contents kept in a reference map by word address
`timescale 1ns/1ps
`default_nettype none
module fsl_host_ctrl_tb_top;
  import fsl_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_nowait = 1'b0;
  logic fail_inject = 1'b0;
  logic [3:0] cmd_op = 4'h0;
  logic [18:0] cmd_addr = '0;
  logic [15:0] cmd_data = '0;
  logic cmd_ready, rsp_valid, rsp_fail, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_dq_oe_n, busy_pull, seen;
  logic [1:0] cfg_shadow;
  logic [18:0] fl_addr, a;
  logic [15:0] rsp_data, fl_dq_o, dev_dq, d;
  wire logic [15:0] fl_dq_i = !fl_dq_oe_n ? fl_dq_o : dev_dq;
  wire logic fl_ready = !busy_pull;
  int miscompares = 0;
  int n_tests = 0;
  integer seed = 37;
  logic [15:0] ref_mem [int];
  always #5 core_clk = ~core_clk;
  fsl_host_ctrl i_dut (.core_clk, .arst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_nowait, .cmd_addr, .cmd_data,
    .rsp_valid, .rsp_fail, .rsp_data, .cfg_shadow, .fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n,
    .fl_dq_o, .fl_dq_oe_n, .fl_dq_i, .fl_ready);
  fsl_flash_model i_flash (.core_clk, .fl_addr, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n, .dq(fl_dq_i),
    .fail_inject, .dev_dq, .busy_pull);
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] exp_of(input logic [18:0] ad);
    return ref_mem.exists(int'(ad)) ? ref_mem[int'(ad)] : 16'hFFFF;
  endfunction : exp_of
  task automatic op(input logic [3:0] o, input logic [18:0] ad, input logic [15:0] dt, input logic nw);
    int n;
    n = 0;
    seen = 1'b0;
    @(negedge core_clk);
    cmd_op = o;
    cmd_addr = ad;
    cmd_data = dt;
    cmd_nowait = nw;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1) begin
      if (fl_ready === 1'b0) seen = 1'b1;
      n++;
      if (n > 9000) begin
        miscompares++;
        $display("MISMATCH %0t no answer", $time);
        stop_test();
      end
      @(negedge core_clk);
    end
  endtask : op
  task automatic rd(input logic [18:0] ad, input logic [15:0] ex);
    op(OP_READ, ad, 16'h0000, 1'b0);
    chk(rsp_data, ex);
  endtask : rd
  task automatic idr(input logic [18:0] ad, input logic [15:0] ex);
    op(OP_ID_READ, ad, 16'h0000, 1'b0);
    chk(rsp_data, ex);
  endtask : idr
  // a failed program must not be folded into the reference
  task automatic pgm(input logic [18:0] ad, input logic [15:0] dt, input logic ef);
    op(OP_PROGRAM, ad, dt, 1'b0);
    chk(16'(rsp_fail), 16'(ef));
    chk(16'(seen), 16'(!ef || fail_inject));
    if (!ef) ref_mem[int'(ad)] = exp_of(ad) & dt;
    rd(ad, exp_of(ad));
  endtask : pgm
  task automatic sus(input logic [18:0] ra, input logic [15:0] rx, input logic [18:0] pa, input logic [15:0] pd);
    op(OP_SUSPEND, pa, 16'h0000, 1'b0);
    chk(16'(fl_ready), 16'h0001);
    rd(ra, rx);
    op(OP_RESUME, pa, 16'h0000, 1'b0);
    op(OP_POLL, pa, pd, 1'b0);
    chk(16'(rsp_fail), 16'h0000);
  endtask : sus
  initial begin
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(16'(cfg_shadow), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      a = {4'h1, 15'($random(seed))};
      d = 16'($random(seed));
      if (i == 2) op(OP_SET_CFG, ADR_UNLOCK1, 16'(CFG_HOLD), 1'b0);
      chk(16'(cfg_shadow), i < 2 ? 16'h0000 : 16'h0001);
      pgm(a, d, 1'b0);
    end
    op(OP_SET_CFG, ADR_UNLOCK1, 16'h0000, 1'b0);
    pgm(19'h10005, 16'h1234, 1'b0);
    pgm(19'h20001, 16'h00AA, 1'b0);
    op(OP_LOCKDOWN, 19'h10000, 16'h0000, 1'b0);
    idr(19'h10002, 16'h0001);
    idr(19'h08002, 16'h0000);
    pgm(19'h10005, 16'h0000, 1'b1);
    op(OP_SECTOR_ERASE, 19'h10000, 16'h0000, 1'b0);
    chk(16'(rsp_fail), 16'h0001);
    rd(19'h10005, 16'h1234);
    fail_inject = 1'b1;
    pgm(19'h18000, 16'h00FF, 1'b1);
    fail_inject = 1'b0;
    op(OP_SECTOR_ERASE, 19'h08000, 16'h0000, 1'b1);
    sus(19'h10005, 16'h1234, 19'h08000, 16'h0080);
    rd(a, 16'hFFFF);
    op(OP_SECTOR_ERASE, 19'h08000, 16'h0000, 1'b1);
    op(OP_SUSPEND, 19'h08000, 16'h0000, 1'b0);
    op(OP_SECTOR_ERASE, 19'h20000, 16'h0000, 1'b1);
    op(OP_RESUME, 19'h08000, 16'h0000, 1'b0);
    op(OP_POLL, 19'h08000, 16'h0080, 1'b0);
    rd(19'h20001, 16'h00AA);
    op(OP_PROGRAM, 19'h28000, 16'h0F0F, 1'b1);
    sus(19'h20001, 16'h00AA, 19'h28000, 16'h0F0F);
    rd(19'h28000, 16'h0F0F);
    op(OP_CHIP_ERASE, 19'h00000, 16'h0000, 1'b1);
    sus(19'h10005, 16'h1234, 19'h28000, 16'h0080);
    rd(19'h28000, 16'hFFFF);
    rd(19'h10005, 16'h1234);
    op(OP_PROT_PGM, 19'h00084, 16'hA5A5, 1'b1);
    idr(19'h00084, 16'hA5A5);
    idr(19'h00080, 16'hFFFF);
    op(OP_PROT_LOCK, 19'h00080, 16'hFFFF, 1'b1);
    op(OP_PROT_PGM, 19'h00084, 16'h0000, 1'b1);
    idr(19'h00084, 16'hA5A5);
    idr(19'h00080, 16'hFFFD);
    rd(19'h10005, 16'h1234);
    arst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(16'(cfg_shadow), 16'h0000);
    idr(19'h10002, 16'h0000);
    pgm(19'h10006, 16'h00F0, 1'b0);
    stop_test();
  end
endmodule : fsl_host_ctrl_tb_top
`default_nettype wire

// file: rtl/fsl_bus_cycle.sv
// Purpose: one asynchronous flash bus cycle, write or read
// Assumes: request held stable until done
// Notes: strobe and recovery lengths come from the package
`timescale 1ns/1ps
`default_nettype none
module fsl_bus_cycle (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bc_req,
  input wire logic bc_wr,
  input wire logic [fsl_pkg::ADDR_W-1:0] bc_addr,
  input wire logic [fsl_pkg::DATA_W-1:0] bc_wdata,
  output logic bc_done,
  output logic [fsl_pkg::DATA_W-1:0] bc_rdata,
  output logic [fsl_pkg::ADDR_W-1:0] fl_addr,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic [fsl_pkg::DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_n,
  input wire logic [fsl_pkg::DATA_W-1:0] fl_dq_i
);
  import fsl_pkg::*;
  typedef enum logic [3:0] {
    B_IDLE = 4'h1, B_SETUP = 4'h2, B_STROBE = 4'h4, B_RECOVER = 4'h8
  } fsl_bstate_t;
  fsl_bstate_t bstate, next_bstate;
  logic [3:0] cnt, next_cnt;
  logic wr, next_wr;
  logic [ADDR_W-1:0] next_fl_addr;
  logic [DATA_W-1:0] next_fl_dq_o, next_bc_rdata;
  logic next_ce_n, next_oe_n, next_we_n, next_dq_oe_n;

  always_comb begin
    next_bstate = bstate;
    next_cnt = cnt;
    next_wr = wr;
    next_fl_addr = fl_addr;
    next_fl_dq_o = fl_dq_o;
    next_bc_rdata = bc_rdata;
    next_ce_n = fl_ce_n;
    next_oe_n = fl_oe_n;
    next_we_n = fl_we_n;
    next_dq_oe_n = fl_dq_oe_n;
    case (bstate)
      B_IDLE: if (bc_req) begin
        next_bstate = B_SETUP;
        next_wr = bc_wr;
        next_fl_addr = bc_addr;
        next_fl_dq_o = bc_wdata;
        next_ce_n = 1'b0;
        next_dq_oe_n = !bc_wr;
      end
      B_SETUP: begin
        next_bstate = B_STROBE;
        next_cnt = STROBE_CYC - 4'h1;
        next_we_n = !wr;
        next_oe_n = wr;
      end
      B_STROBE: if (cnt == 4'h0) begin
        // data is taken as the strobe rises, so sample on the last low cycle
        next_bc_rdata = fl_dq_i;
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        next_bstate = B_RECOVER;
        next_cnt = RECOVER_CYC - 4'h1;
      end else begin
        next_cnt = cnt - 4'h1;
      end
      B_RECOVER: if (cnt == 4'h0) begin
        next_bstate = B_IDLE;
        next_ce_n = 1'b1;
        next_dq_oe_n = 1'b1;
      end else begin
        next_cnt = cnt - 4'h1;
      end
      default: next_bstate = B_IDLE;
    endcase
  end

  assign bc_done = (bstate == B_RECOVER) && (cnt == 4'h0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bstate <= B_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      fl_addr <= '0;
      fl_dq_o <= '0;
      bc_rdata <= '0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_dq_oe_n <= 1'b1;
    end else begin
      bstate <= next_bstate;
      cnt <= next_cnt;
      wr <= next_wr;
      fl_addr <= next_fl_addr;
      fl_dq_o <= next_fl_dq_o;
      bc_rdata <= next_bc_rdata;
      fl_ce_n <= next_ce_n;
      fl_oe_n <= next_oe_n;
      fl_we_n <= next_we_n;
      fl_dq_oe_n <= next_dq_oe_n;
    end
  end

  a_we_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(fl_we_n) |-> !fl_we_n [*6] ##1 fl_we_n) else $error("write strobe width wrong");
  a_no_both_strobes: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(!fl_we_n && !fl_oe_n)) else $error("read and write strobes overlap");
endmodule : fsl_bus_cycle
`default_nettype wire

// file: rtl/fsl_host_ctrl.sv
// Purpose: host controller that drives a parallel NOR flash by command sequences
// Assumes: flash data and ready pins synchronous to core_clk
// Notes: one operation at a time; polls with the toggle bit, gated by the ready line
// Summary of operation
// - config 01: host issues exit after success
// - any failure: host issues exit afterwards
// - lock command fourth cycle bit1 zero
// - host exits identify mode after reading
`timescale 1ns/1ps
`default_nettype none
module fsl_host_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic cmd_nowait,
  input wire logic [fsl_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [fsl_pkg::DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic rsp_fail,
  output logic [fsl_pkg::DATA_W-1:0] rsp_data,
  output logic [1:0] cfg_shadow,
  output logic [fsl_pkg::ADDR_W-1:0] fl_addr,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_reset_n,
  output logic [fsl_pkg::DATA_W-1:0] fl_dq_o,
  output logic fl_dq_oe_n,
  input wire logic [fsl_pkg::DATA_W-1:0] fl_dq_i,
  input wire logic fl_ready
);
  import fsl_pkg::*;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_CMD = 8'h02, ST_READ = 8'h04, ST_POLL_A = 8'h08,
    ST_POLL_B = 8'h10, ST_SUSP = 8'h20, ST_EXIT = 8'h40, ST_DONE = 8'h80
  } fsl_state_t;

  function automatic logic [2:0] seq_len(input logic [3:0] op);
    case (op)
      OP_PROGRAM, OP_SET_CFG, OP_PROT_PGM, OP_PROT_LOCK: seq_len = 3'h4;
      OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_LOCKDOWN: seq_len = 3'h6;
      OP_ID_READ, OP_EXIT: seq_len = 3'h3;
      OP_SUSPEND, OP_RESUME: seq_len = 3'h1;
      default: seq_len = 3'h0;
    endcase
  endfunction : seq_len

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [3:0] op, input logic [2:0] idx,
                                                 input logic [ADDR_W-1:0] ua);
    seq_addr = ADR_UNLOCK1;
    if (idx == 3'h1 || idx == 3'h4) seq_addr = ADR_UNLOCK2;
    else if (op == OP_SUSPEND || op == OP_RESUME) seq_addr = ua;
    else if (idx == 3'h5 && op != OP_CHIP_ERASE) seq_addr = ua;
    else if (idx == 3'h3 && (op == OP_PROGRAM || op == OP_PROT_PGM || op == OP_PROT_LOCK)) seq_addr = ua;
  endfunction : seq_addr

  function automatic logic [DATA_W-1:0] seq_data(input logic [3:0] op, input logic [2:0] idx,
                                                 input logic [DATA_W-1:0] ud);
    logic [7:0] code;
    code = DAT_UNLOCK1;
    case (idx)
      3'h0: begin
        if (op == OP_SUSPEND) code = DAT_SUSPEND;
        else if (op == OP_RESUME) code = DAT_RESUME;
      end
      3'h1, 3'h4: code = DAT_UNLOCK2;
      3'h2: begin
        case (op)
          OP_PROGRAM: code = DAT_PROGRAM;
          OP_SET_CFG: code = DAT_SET_CFG;
          OP_PROT_PGM: code = DAT_PROT_PGM;
          OP_PROT_LOCK: code = DAT_PROT_LOCK;
          OP_ID_READ: code = DAT_ID_ENTRY;
          OP_EXIT: code = DAT_ID_EXIT;
          default: code = DAT_SETUP;
        endcase
      end
      3'h5: begin
        if (op == OP_CHIP_ERASE) code = DAT_CHIP_ERASE;
        else if (op == OP_LOCKDOWN) code = DAT_LOCKDOWN;
        else code = DAT_SECTOR_ERASE;
      end
      default: code = DAT_UNLOCK1;
    endcase
    seq_data = {8'h00, code};
    if (idx == 3'h3) begin
      if (op == OP_SET_CFG) seq_data = {14'h0000, ud[1:0]};
      else if (op == OP_PROT_LOCK) seq_data = ud & ~(16'h0001 << BLOCK_LOCK_BIT);
      else if (op != OP_SECTOR_ERASE && op != OP_CHIP_ERASE && op != OP_LOCKDOWN) seq_data = ud;
    end
  endfunction : seq_data

  logic rs_meta, rst_n;
  fsl_state_t state, next_state;
  logic [3:0] op, next_op;
  logic [ADDR_W-1:0] ua, next_ua;
  logic [DATA_W-1:0] ud, next_ud, prev, next_prev, next_rsp_data;
  logic [2:0] step, next_step;
  logic [1:0] next_cfg;
  logic exp7, next_exp7, retry, next_retry, next_fail, exit_seen, next_exit_seen;
  logic [11:0] wait_cnt, next_wait_cnt;
  logic cmd_nowait_q, next_nowait;
  logic bc_req, bc_wr, bc_done, toggled, last;
  logic [3:0] bc_op;
  logic [ADDR_W-1:0] bc_addr;
  logic [DATA_W-1:0] bc_wdata, bc_rdata;

  // reset release through two flops; flash reset follows it so lockdowns clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs_meta <= 1'b1;
      rst_n <= rs_meta;
    end
  end
  assign fl_reset_n = rst_n;

  assign bc_op = (state == ST_EXIT) ? OP_EXIT : op;
  assign bc_wr = (state == ST_CMD) || (state == ST_EXIT);
  assign bc_addr = bc_wr ? seq_addr(bc_op, step, ua) : ua;
  assign bc_wdata = seq_data(bc_op, step, ud);
  // polling waits for the ready line so no read is spent while busy
  assign bc_req = bc_wr || (state == ST_READ) ||
                  ((state == ST_POLL_A || state == ST_POLL_B) && fl_ready);
  assign last = (step == seq_len(bc_op) - 3'h1);
  assign toggled = prev[TOGGLE_BIT] != bc_rdata[TOGGLE_BIT];
  assign cmd_ready = (state == ST_IDLE);
  assign rsp_valid = (state == ST_DONE);

  always_comb begin
    next_state = state;
    next_op = op;
    next_ua = ua;
    next_ud = ud;
    next_prev = prev;
    next_step = step;
    next_cfg = cfg_shadow;
    next_exp7 = exp7;
    next_retry = retry;
    next_fail = rsp_fail;
    next_exit_seen = exit_seen;
    next_wait_cnt = wait_cnt;
    next_rsp_data = rsp_data;
    case (state)
      ST_IDLE: if (cmd_valid) begin
        next_op = cmd_op;
        next_ua = cmd_addr;
        next_ud = cmd_data;
        next_step = 3'h0;
        next_fail = 1'b0;
        next_retry = 1'b0;
        next_exit_seen = 1'b0;
        // erase leaves ones; a program polls for the true bit
        next_exp7 = (cmd_op == OP_PROGRAM || cmd_op == OP_POLL || cmd_op == OP_PROT_PGM) ?
                    cmd_data[POLL_BIT] : 1'b1;
        if (cmd_op == OP_READ) next_state = ST_READ;
        else if (cmd_op == OP_POLL) next_state = ST_POLL_A;
        else next_state = ST_CMD;
      end
      ST_CMD: if (bc_done) begin
        next_step = step + 3'h1;
        if (last) begin
          next_step = 3'h0;
          case (op)
            OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_PROT_PGM, OP_PROT_LOCK:
              next_state = cmd_nowait_q ? ST_DONE : ST_POLL_A;
            OP_ID_READ: next_state = ST_READ;
            OP_SUSPEND: begin
              next_wait_cnt = SUSP_WAIT_CYC;
              next_state = ST_SUSP;
            end
            OP_SET_CFG: begin
              next_cfg = ud[1:0];
              next_state = ST_DONE;
            end
            OP_EXIT: begin
              next_exit_seen = 1'b1;
              next_state = ST_DONE;
            end
            default: next_state = ST_DONE;
          endcase
        end
      end
      ST_READ: if (bc_done) begin
        next_rsp_data = bc_rdata;
        next_state = (op == OP_ID_READ) ? ST_EXIT : ST_DONE;
      end
      ST_POLL_A: if (bc_done) begin
        next_prev = bc_rdata;
        next_state = ST_POLL_B;
      end
      ST_POLL_B: if (bc_done) begin
        next_rsp_data = bc_rdata;
        if (toggled) begin
          next_state = ST_POLL_A;
          // still toggling with the failure flag up twice in a row: give up
          next_retry = bc_rdata[FAIL_BIT];
          if (retry && bc_rdata[FAIL_BIT]) begin
            next_fail = 1'b1;
            next_state = ST_EXIT;
          end
        end else if (bc_rdata[FAIL_BIT] &&
                     (cfg_shadow == CFG_HOLD || bc_rdata[POLL_BIT] != exp7)) begin
          next_fail = 1'b1;
          next_state = ST_EXIT;
        end else if (cfg_shadow == CFG_HOLD) begin
          next_state = ST_EXIT;
        end else begin
          next_state = ST_DONE;
        end
      end
      ST_SUSP: begin
        next_wait_cnt = wait_cnt - 12'h001;
        if (wait_cnt == 12'h000) next_state = ST_DONE;
      end
      ST_EXIT: if (bc_done) begin
        next_step = step + 3'h1;
        if (last) begin
          next_step = 3'h0;
          next_exit_seen = 1'b1;
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_comb begin
    next_nowait = cmd_nowait_q;
    if (state == ST_IDLE && cmd_valid) next_nowait = cmd_nowait;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= OP_READ;
      ua <= '0;
      ud <= '0;
      prev <= '0;
      step <= 3'h0;
      cfg_shadow <= CFG_RESET;
      exp7 <= 1'b1;
      retry <= 1'b0;
      rsp_fail <= 1'b0;
      exit_seen <= 1'b0;
      wait_cnt <= 12'h000;
      rsp_data <= '0;
      cmd_nowait_q <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      ua <= next_ua;
      ud <= next_ud;
      prev <= next_prev;
      step <= next_step;
      cfg_shadow <= next_cfg;
      exp7 <= next_exp7;
      retry <= next_retry;
      rsp_fail <= next_fail;
      exit_seen <= next_exit_seen;
      wait_cnt <= next_wait_cnt;
      rsp_data <= next_rsp_data;
      cmd_nowait_q <= next_nowait;
    end
  end

  fsl_bus_cycle u_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bc_req(bc_req),
    .bc_wr(bc_wr),
    .bc_addr(bc_addr),
    .bc_wdata(bc_wdata),
    .bc_done(bc_done),
    .bc_rdata(bc_rdata),
    .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_dq_i(fl_dq_i)
  );

  a_fail_then_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
    rsp_valid && rsp_fail |-> exit_seen) else $error("failure answered without exit");
  a_hold_cfg_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_POLL_B && bc_done && !toggled && cfg_shadow == CFG_HOLD) |=> state == ST_EXIT)
    else $error("hold config success without exit");
  a_lock_bit_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_CMD && op == OP_PROT_LOCK && step == 3'h3) |-> !bc_wdata[BLOCK_LOCK_BIT])
    else $error("lock cycle data bit1 not zero");
  a_id_read_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_READ && bc_done && op == OP_ID_READ) |=> state == ST_EXIT ##[1:60] exit_seen)
    else $error("identify read not followed by exit");
  a_susp_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_SUSP) |-> !rsp_valid [*8]) else $error("suspend wait too short");
  c_program_ok: cover property (@(posedge core_clk) rsp_valid && !rsp_fail && op == OP_PROGRAM);
  c_fail_exit: cover property (@(posedge core_clk) rsp_valid && rsp_fail);
  c_id_read: cover property (@(posedge core_clk) rsp_valid && op == OP_ID_READ);
endmodule : fsl_host_ctrl
`default_nettype wire

// file: rtl/fsl_pkg.sv
// Purpose: shared constants for the flash status/lock/suspend host controller
// Assumes: 100 MHz core clock, word-mode parallel flash bus
// Notes: command data codes not fixed by the unlock table are plain defaults
package fsl_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 10;
  // bus timing of one strobe and the gap after it
  localparam int T_STROBE_NS = 60;
  localparam int T_RECOVER_NS = 30;
  localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RECOVER_CYC = 4'((T_RECOVER_NS + CLK_NS - 1) / CLK_NS);
  // longest suspend latency of the device; the host waits the larger one
  localparam int T_ERS_SUSP_US = 15;
  localparam int T_PGM_SUSP_US = 20;
  localparam int SUSP_MAX_US = (T_PGM_SUSP_US > T_ERS_SUSP_US) ? T_PGM_SUSP_US : T_ERS_SUSP_US;
  localparam logic [11:0] SUSP_WAIT_CYC = 12'((SUSP_MAX_US * 1000 + CLK_NS - 1) / CLK_NS);
  // unlock addresses and codes
  localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 19'h00555;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 19'h00AAA;
  localparam logic [ADDR_W-1:0] ADR_USER_LOCK = 19'h00080;
  localparam logic [ADDR_W-1:0] ADR_LOCK_IND_OFS = 19'h00002;
  localparam logic [7:0] DAT_UNLOCK1 = 8'hAA;
  localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0] DAT_SETUP = 8'h80;
  localparam logic [7:0] DAT_PROGRAM = 8'hA0;
  localparam logic [7:0] DAT_CHIP_ERASE = 8'h10;
  localparam logic [7:0] DAT_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] DAT_LOCKDOWN = 8'h60;
  localparam logic [7:0] DAT_SET_CFG = 8'hD0;
  localparam logic [7:0] DAT_SUSPEND = 8'hB0;
  localparam logic [7:0] DAT_RESUME = 8'hB1;
  localparam logic [7:0] DAT_ID_ENTRY = 8'h90;
  localparam logic [7:0] DAT_ID_EXIT = 8'hF0;
  localparam logic [7:0] DAT_PROT_PGM = 8'hC0;
  localparam logic [7:0] DAT_PROT_LOCK = 8'hC1;
  // status bit positions on the data pins
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int LOCK_IND_BIT = 0;
  localparam int BLOCK_LOCK_BIT = 1;
  // status behaviour configuration values
  localparam logic [1:0] CFG_AUTO = 2'h0;
  localparam logic [1:0] CFG_HOLD = 2'h1;
  localparam logic [1:0] CFG_RESET = CFG_AUTO;
  // user operations
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h2;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h3;
  localparam logic [3:0] OP_SET_CFG = 4'h4;
  localparam logic [3:0] OP_LOCKDOWN = 4'h5;
  localparam logic [3:0] OP_SUSPEND = 4'h6;
  localparam logic [3:0] OP_RESUME = 4'h7;
  localparam logic [3:0] OP_ID_READ = 4'h8;
  localparam logic [3:0] OP_PROT_PGM = 4'h9;
  localparam logic [3:0] OP_PROT_LOCK = 4'hA;
  localparam logic [3:0] OP_EXIT = 4'hB;
  localparam logic [3:0] OP_POLL = 4'hC;
endpackage : fsl_pkg
